//--- design/dual_timer_counter_pair.sv
`timescale 1ns/1ps
// Operation
// - Mode 3 splits timer zero into two independent 8-bit timers.
// - Split low byte keeps timer zero's source, gate, run and overflow bits.
// - Split high byte counts clock/12, runs on timer one run, sets its flag.
// - Timer one in mode 3 stops and holds its count.
// - Timer one uses mode bits 7..4 and control bits 7, 6.
// - Gate clear: run alone enables; gate set: also needs interrupt pin high.
// - Source 0 counts divided clock; source 1 counts count-pin falling edges.
// - Mode fields: timer one bits 5..4, timer zero bits 1..0.
// - Overflow sets flag; vectoring to the interrupt clears it.
// - Pin event sets interrupt flag; edge flag clears when processed.
// - Edge-select 1 triggers falling edge; 0 triggers active-low level.
// - Timer one rollover to zero sets timer one overflow flag, except with timer zero in mode 3.
// - Mode 0: 5-bit prescaler in low byte carries into 8-bit high byte.
// - Mode 1: high and low bytes cascade as one 16-bit counter.
// - Timer one matches timer zero in modes 0-2; overflow pulse for baud.
// - Timer operation increments once per 12-clock peripheral cycle.
// - Counter samples pin each peripheral cycle, counts high-then-low.
// - Mode 2: low byte reloads from unchanged high byte on overflow.
module dual_timer_counter_pair
  import timer_pair_pkg::*;
(
  // Clock and reset
  input  wire logic                ref_clk,
  input  wire logic                rst_b,
  // Avalon-MM slave
  input  wire logic [ADDR_W-1:0]   avs_address,
  input  wire logic                avs_read,
  input  wire logic                avs_write,
  input  wire logic [DATA_W-1:0]   avs_writedata,
  input  wire logic [3:0]          avs_byteenable,
  output logic      [DATA_W-1:0]   avs_readdata,
  output logic                     avs_waitrequest,
  // Pins
  input  wire logic                timer_zero_count_pin,
  input  wire logic                timer_one_count_pin,
  input  wire logic                ext_irq_zero_pin,
  input  wire logic                ext_irq_one_pin,
  // Processor interrupt logic
  input  wire vector_ack_s         vector_ack,
  output logic                     timer_zero_overflow_flag,
  output logic                     timer_one_overflow_flag,
  output logic                     ext_irq_zero_flag,
  output logic                     ext_irq_one_flag,
  output logic                     timer_one_overflow_pulse
);

  mode_sel_s   timer_mode_select_q;
  logic        timer_zero_run_q;
  logic        timer_one_run_q;
  logic        ext_irq_zero_edge_select_q;
  logic        ext_irq_one_edge_select_q;
  logic [7:0]  timer_zero_low_byte_q;
  logic [7:0]  timer_zero_high_byte_q;
  logic [7:0]  timer_one_low_byte_q;
  logic [7:0]  timer_one_high_byte_q;
  logic [3:0]  div_q;
  logic        tick;
  logic [3:0]  meta_q;
  logic [3:0]  sync_q;
  logic [3:0]  prev_q;
  logic        zero_samp_q;
  logic        one_samp_q;
  logic        zero_fall_q;
  logic        one_fall_q;

  // Input synchronisers: count0, count1, irq0, irq1
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      meta_q <= 4'hF;
      sync_q <= 4'hF;
      prev_q <= 4'hF;
    end else begin
      meta_q <= {ext_irq_one_pin, ext_irq_zero_pin, timer_one_count_pin, timer_zero_count_pin};
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      div_q <= 4'h0;
    end else if (div_q == PERIPH_LAST) begin
      div_q <= 4'h0;
    end else begin
      div_q <= div_q + 4'h1;
    end
  end
  assign tick = (div_q == PERIPH_LAST);

  // Sample count pins once per peripheral cycle
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      zero_samp_q <= 1'b1;
      one_samp_q  <= 1'b1;
      zero_fall_q <= 1'b0;
      one_fall_q  <= 1'b0;
    end else if (tick) begin
      zero_samp_q <= sync_q[0];
      one_samp_q  <= sync_q[1];
      zero_fall_q <= zero_samp_q & ~sync_q[0];
      one_fall_q  <= one_samp_q & ~sync_q[1];
    end
  end

  // Bus decode
  logic [7:0] wr_byte;
  logic [7:0] bus_idx;
  logic       wr_go;
  logic       wr_ctl;
  logic       word_ok;
  assign wr_byte = avs_writedata[7:0];
  assign bus_idx = avs_address[9:2];
  assign word_ok = (avs_address[1:0] == 2'b00);
  assign wr_go   = avs_write & ~avs_waitrequest & avs_byteenable[0] & word_ok;
  assign wr_ctl  = wr_go & (bus_idx == IDX_CONTROL_FLAGS);

  logic zero_en;
  logic one_en;
  logic zero_inc;
  logic one_inc;
  logic split_high_inc;
  assign zero_en = timer_zero_run_q & (~timer_mode_select_q.zero_gate | sync_q[2]);
  assign one_en  = timer_one_run_q & (~timer_mode_select_q.one_gate | sync_q[3]);
  // Source select; counter edge resolved one tick late
  assign zero_inc = tick & zero_en & (~timer_mode_select_q.zero_src | zero_fall_q);
  assign one_inc  = tick & one_en & (~timer_mode_select_q.one_src | one_fall_q);
  // Split high byte is clock/12 only
  assign split_high_inc = tick & timer_one_run_q;

  logic zero_split;
  assign zero_split = (timer_mode_select_q.zero_mode == MODE_SPLIT);

  logic zero_ovf;
  logic zero_high_ovf;
  logic one_ovf;

  // Timer zero counting; a software write to a count byte wins
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      timer_zero_low_byte_q  <= RESET_BYTE;
      timer_zero_high_byte_q <= RESET_BYTE;
      zero_ovf      <= 1'b0;
      zero_high_ovf <= 1'b0;
    end else begin
      zero_ovf      <= 1'b0;
      zero_high_ovf <= 1'b0;
      if (zero_inc) begin
        unique case (timer_mode_select_q.zero_mode)
          MODE_13BIT: begin
            timer_zero_low_byte_q[4:0] <= timer_zero_low_byte_q[4:0] + 5'h01;
            if (timer_zero_low_byte_q[4:0] == PRESCALE_LAST) begin
              timer_zero_high_byte_q <= timer_zero_high_byte_q + 8'h01;
              zero_ovf <= (timer_zero_high_byte_q == BYTE_LAST);
            end
          end
          MODE_16BIT: begin
            timer_zero_low_byte_q <= timer_zero_low_byte_q + 8'h01;
            if (timer_zero_low_byte_q == BYTE_LAST) begin
              timer_zero_high_byte_q <= timer_zero_high_byte_q + 8'h01;
              zero_ovf <= (timer_zero_high_byte_q == BYTE_LAST);
            end
          end
          MODE_RELOAD: begin
            if (timer_zero_low_byte_q == BYTE_LAST) begin
              timer_zero_low_byte_q <= timer_zero_high_byte_q;
              zero_ovf <= 1'b1;
            end else begin
              timer_zero_low_byte_q <= timer_zero_low_byte_q + 8'h01;
            end
          end
          MODE_SPLIT: begin
            timer_zero_low_byte_q <= timer_zero_low_byte_q + 8'h01;
            zero_ovf <= (timer_zero_low_byte_q == BYTE_LAST);
          end
        endcase
      end
      // Split high byte on timer one run
      if (zero_split && split_high_inc) begin
        timer_zero_high_byte_q <= timer_zero_high_byte_q + 8'h01;
        zero_high_ovf <= (timer_zero_high_byte_q == BYTE_LAST);
      end
      if (wr_go && bus_idx == IDX_ZERO_LOW) begin
        timer_zero_low_byte_q <= wr_byte;
      end
      if (wr_go && bus_idx == IDX_ZERO_HIGH) begin
        timer_zero_high_byte_q <= wr_byte;
      end
    end
  end

  // Timer one counting
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      timer_one_low_byte_q  <= RESET_BYTE;
      timer_one_high_byte_q <= RESET_BYTE;
      one_ovf <= 1'b0;
    end else begin
      one_ovf <= 1'b0;
      if (one_inc) begin
        // Same as timer zero in modes 0-2
        unique case (timer_mode_select_q.one_mode)
          MODE_13BIT: begin
            timer_one_low_byte_q[4:0] <= timer_one_low_byte_q[4:0] + 5'h01;
            if (timer_one_low_byte_q[4:0] == PRESCALE_LAST) begin
              timer_one_high_byte_q <= timer_one_high_byte_q + 8'h01;
              one_ovf <= (timer_one_high_byte_q == BYTE_LAST);
            end
          end
          MODE_16BIT: begin
            timer_one_low_byte_q <= timer_one_low_byte_q + 8'h01;
            if (timer_one_low_byte_q == BYTE_LAST) begin
              timer_one_high_byte_q <= timer_one_high_byte_q + 8'h01;
              one_ovf <= (timer_one_high_byte_q == BYTE_LAST);
            end
          end
          MODE_RELOAD: begin
            if (timer_one_low_byte_q == BYTE_LAST) begin
              timer_one_low_byte_q <= timer_one_high_byte_q;
              one_ovf <= 1'b1;
            end else begin
              timer_one_low_byte_q <= timer_one_low_byte_q + 8'h01;
            end
          end
          MODE_SPLIT: begin
            timer_one_low_byte_q <= timer_one_low_byte_q;
          end
        endcase
      end
      if (wr_go && bus_idx == IDX_ONE_LOW) begin
        timer_one_low_byte_q <= wr_byte;
      end
      if (wr_go && bus_idx == IDX_ONE_HIGH) begin
        timer_one_high_byte_q <= wr_byte;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      timer_one_overflow_pulse <= 1'b0;
    end else begin
      timer_one_overflow_pulse <= one_ovf;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      timer_mode_select_q <= mode_sel_s'(RESET_BYTE);
    end else if (wr_go && bus_idx == IDX_MODE_SELECT) begin
      timer_mode_select_q <= mode_sel_s'(wr_byte);
    end
  end

  // Run and edge-select bits, software only
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      timer_one_run_q            <= 1'b0;
      timer_zero_run_q           <= 1'b0;
      ext_irq_one_edge_select_q  <= 1'b0;
      ext_irq_zero_edge_select_q <= 1'b0;
    end else if (wr_ctl) begin
      timer_one_run_q            <= wr_byte[POS_ONE_RUN];
      timer_zero_run_q           <= wr_byte[POS_ZERO_RUN];
      ext_irq_one_edge_select_q  <= wr_byte[POS_IRQ1_EDGE];
      ext_irq_zero_edge_select_q <= wr_byte[POS_IRQ0_EDGE];
    end
  end

  // Overflow flags; hardware set beats any clear
  logic one_flag_set;
  assign one_flag_set = zero_split ? zero_high_ovf : one_ovf;
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      timer_zero_overflow_flag <= 1'b0;
      timer_one_overflow_flag  <= 1'b0;
    end else begin
      if (zero_ovf) begin
        timer_zero_overflow_flag <= 1'b1;
      end else if (vector_ack.zero) begin
        timer_zero_overflow_flag <= 1'b0;
      end else if (wr_ctl) begin
        timer_zero_overflow_flag <= wr_byte[POS_ZERO_OVF];
      end
      // Split high byte owns this flag; timer one overflow then unflagged
      if (one_flag_set) begin
        timer_one_overflow_flag <= 1'b1;
      end else if (vector_ack.one) begin
        timer_one_overflow_flag <= 1'b0;
      end else if (wr_ctl) begin
        timer_one_overflow_flag <= wr_byte[POS_ONE_OVF];
      end
    end
  end

  logic irq0_fall;
  logic irq1_fall;
  assign irq0_fall = prev_q[2] & ~sync_q[2];
  assign irq1_fall = prev_q[3] & ~sync_q[3];
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      ext_irq_zero_flag <= 1'b0;
      ext_irq_one_flag  <= 1'b0;
    end else begin
      if (!ext_irq_zero_edge_select_q) begin
        ext_irq_zero_flag <= ~sync_q[2];
      end else if (irq0_fall) begin
        ext_irq_zero_flag <= 1'b1;
      end else if (vector_ack.irq0) begin
        ext_irq_zero_flag <= 1'b0;
      end else if (wr_ctl) begin
        ext_irq_zero_flag <= wr_byte[POS_IRQ0_FLAG];
      end
      if (!ext_irq_one_edge_select_q) begin
        ext_irq_one_flag <= ~sync_q[3];
      end else if (irq1_fall) begin
        ext_irq_one_flag <= 1'b1;
      end else if (vector_ack.irq1) begin
        ext_irq_one_flag <= 1'b0;
      end else if (wr_ctl) begin
        ext_irq_one_flag <= wr_byte[POS_IRQ1_FLAG];
      end
    end
  end

  // Avalon answer one cycle after the request; unmapped reads give zero
  logic [7:0] rd_byte;
  always_comb begin
    rd_byte = 8'h00;
    if (word_ok) begin
      unique case (bus_idx)
        IDX_CONTROL_FLAGS: rd_byte = {timer_one_overflow_flag, timer_one_run_q,
                                      timer_zero_overflow_flag, timer_zero_run_q,
                                      ext_irq_one_flag, ext_irq_one_edge_select_q,
                                      ext_irq_zero_flag, ext_irq_zero_edge_select_q};
        IDX_MODE_SELECT:   rd_byte = timer_mode_select_q;
        IDX_ZERO_LOW:      rd_byte = timer_zero_low_byte_q;
        IDX_ZERO_HIGH:     rd_byte = timer_zero_high_byte_q;
        IDX_ONE_LOW:       rd_byte = timer_one_low_byte_q;
        IDX_ONE_HIGH:      rd_byte = timer_one_high_byte_q;
        default:           rd_byte = 8'h00;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0000_0000;
    end else begin
      avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest);
      if (avs_read && avs_waitrequest) begin
        avs_readdata <= {24'h00_0000, rd_byte};
      end
    end
  end

endmodule

//--- design/timer_pair_pkg.sv
package timer_pair_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_CONTROL_FLAGS = 8'h88;
  localparam logic [7:0] IDX_MODE_SELECT   = 8'h89;
  localparam logic [7:0] IDX_ZERO_LOW      = 8'h8A;
  localparam logic [7:0] IDX_ONE_LOW       = 8'h8B;
  localparam logic [7:0] IDX_ZERO_HIGH     = 8'h8C;
  localparam logic [7:0] IDX_ONE_HIGH      = 8'h8D;

  localparam int          ADDR_W     = 10;
  localparam int          DATA_W     = 32;
  localparam logic [7:0]  RESET_BYTE = 8'h00;

  // Control register bit positions
  localparam int POS_ONE_OVF   = 7;
  localparam int POS_ONE_RUN   = 6;
  localparam int POS_ZERO_OVF  = 5;
  localparam int POS_ZERO_RUN  = 4;
  localparam int POS_IRQ1_FLAG = 3;
  localparam int POS_IRQ1_EDGE = 2;
  localparam int POS_IRQ0_FLAG = 1;
  localparam int POS_IRQ0_EDGE = 0;

  // Oscillator clocks per peripheral cycle
  localparam int         PERIPH_CLOCKS = 12;
  localparam logic [3:0] PERIPH_LAST   = 4'(PERIPH_CLOCKS - 1);

  localparam logic [4:0] PRESCALE_LAST = 5'h1F;
  localparam logic [7:0] BYTE_LAST     = 8'hFF;

  typedef enum logic [1:0] {
    MODE_13BIT  = 2'b00,
    MODE_16BIT  = 2'b01,
    MODE_RELOAD = 2'b10,
    MODE_SPLIT  = 2'b11
  } timer_mode_e;

  typedef struct packed {
    logic        one_gate;
    logic        one_src;
    timer_mode_e one_mode;
    logic        zero_gate;
    logic        zero_src;
    timer_mode_e zero_mode;
  } mode_sel_s;

  typedef struct packed {
    logic zero;
    logic one;
    logic irq0;
    logic irq1;
  } vector_ack_s;

endpackage

//--- sim/timer_pair_properties.sv
`timescale 1ns/1ps
module timer_pair_properties
  import timer_pair_pkg::*;
(
  // Clock and reset
  input wire logic              ref_clk,
  input wire logic              rst_b,
  // Bus
  input wire logic              avs_read,
  input wire logic              avs_write,
  input wire logic [DATA_W-1:0] avs_readdata,
  input wire logic              avs_waitrequest,
  // Pins and interrupt side
  input wire logic              ext_irq_zero_pin,
  input wire logic              ext_irq_one_pin,
  input wire vector_ack_s       vector_ack,
  input wire logic              timer_zero_overflow_flag,
  input wire logic              timer_one_overflow_flag,
  input wire logic              ext_irq_zero_flag,
  input wire logic              ext_irq_one_flag,
  input wire logic              timer_one_overflow_pulse
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  property p_bus_answer;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_bus_answer: assert property (p_bus_answer) else $error("bus answer late");
  property p_bus_once;
    !avs_waitrequest |=> avs_waitrequest;
  endproperty
  a_bus_once: assert property (p_bus_once) else $error("bus answer too long");
  property p_bus_idle;
    !avs_read && !avs_write |=> avs_waitrequest;
  endproperty
  a_bus_idle: assert property (p_bus_idle) else $error("answer without request");
  property p_read_upper;
    !avs_waitrequest |-> avs_readdata[31:8] == 24'h0;
  endproperty
  a_read_upper: assert property (p_read_upper) else $error("read data upper bits");
  property p_t0_fall;
    $fell(timer_zero_overflow_flag) |->
      $past(vector_ack.zero) || $past(avs_write && !avs_waitrequest);
  endproperty
  a_t0_fall: assert property (p_t0_fall) else $error("zero flag lost");
  property p_t1_fall;
    $fell(timer_one_overflow_flag) |->
      $past(vector_ack.one) || $past(avs_write && !avs_waitrequest);
  endproperty
  a_t1_fall: assert property (p_t1_fall) else $error("one flag lost");
  property p_irq0_rise;
    $rose(ext_irq_zero_flag) |->
      !$past(ext_irq_zero_pin, 2) || $past(avs_write && !avs_waitrequest);
  endproperty
  a_irq0_rise: assert property (p_irq0_rise) else $error("irq zero without pin");
  property p_irq1_rise;
    $rose(ext_irq_one_flag) |->
      !$past(ext_irq_one_pin, 2) || $past(avs_write && !avs_waitrequest);
  endproperty
  a_irq1_rise: assert property (p_irq1_rise) else $error("irq one without pin");
  property p_pulse_gap;
    timer_one_overflow_pulse |=> !timer_one_overflow_pulse [*8];
  endproperty
  a_pulse_gap: assert property (p_pulse_gap) else $error("overflow pulses too close");

  c_ack: cover property (timer_zero_overflow_flag && vector_ack.zero);
  c_pulse: cover property ($rose(timer_one_overflow_pulse));
  c_irq1: cover property ($rose(ext_irq_one_flag));
endmodule

bind dual_timer_counter_pair timer_pair_properties i_timer_pair_properties (
  .ref_clk, .rst_b, .avs_read, .avs_write, .avs_readdata, .avs_waitrequest,
  .ext_irq_zero_pin, .ext_irq_one_pin, .vector_ack, .timer_zero_overflow_flag,
  .timer_one_overflow_flag, .ext_irq_zero_flag, .ext_irq_one_flag,
  .timer_one_overflow_pulse
);

//--- sim/timer_pair_partner.sv
`timescale 1ns/1ps
module timer_pair_partner
  import timer_pair_pkg::*;
(
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst_b,
  // Bench controls and flags
  input  wire logic       count_en,
  input  wire logic       ack_en,
  input  wire logic [3:0] flags,
  // Pin and processor side
  output logic            count_pin,
  output vector_ack_s     vector_ack
);
  logic [4:0] phase_q;
  logic [3:0] hold_q;

  // Each level held a full peripheral cycle; idle high
  always_ff @(posedge ref_clk) begin
    if (!rst_b || !count_en) begin
      phase_q   <= 5'h00;
      count_pin <= 1'b1;
    end else begin
      phase_q <= (phase_q == 5'h0B) ? 5'h00 : phase_q + 5'h01;
      if (phase_q == 5'h0B) begin
        count_pin <= !count_pin;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    vector_ack <= '0;
    if (!rst_b) begin
      hold_q <= 4'h0;
    end else if (hold_q != 4'h0) begin
      hold_q <= hold_q - 4'h1;
    end else if (ack_en && flags != 4'h0) begin
      vector_ack <= vector_ack_s'(flags);
      hold_q     <= 4'h4;
    end
  end
endmodule

//--- sim/testbench.sv
`timescale 1ns/1ps
module testbench
  import timer_pair_pkg::*;
;
  logic              ref_clk = 1'b0;
  logic              rst_b = 1'b0;
  logic [ADDR_W-1:0] avs_address = '0;
  logic              avs_read = 1'b0;
  logic              avs_write = 1'b0;
  logic [DATA_W-1:0] avs_writedata = '0;
  logic [3:0]        avs_byteenable = 4'hF;
  logic [DATA_W-1:0] avs_readdata;
  logic              avs_waitrequest;
  logic [1:0]        irq_pin = 2'b11;
  logic              count_pin;
  logic              count_en = 1'b0;
  logic              ack_en = 1'b0;
  vector_ack_s       vector_ack;
  logic [3:0]        flag;
  logic              t1_pulse;
  logic [DATA_W-1:0] rd;
  int                mismatches = 0;
  int                checked = 0;
  int                cyc = 0;
  int                pulses = 0;

  always #10 ref_clk = ~ref_clk;
  always @(posedge ref_clk) cyc <= cyc + 1;
  always @(posedge ref_clk) if (t1_pulse === 1'b1) pulses <= pulses + 1;

  dual_timer_counter_pair i_dual_timer_counter_pair (
    .ref_clk, .rst_b, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest,
    .timer_zero_count_pin(count_pin), .timer_one_count_pin(count_pin),
    .ext_irq_zero_pin(irq_pin[0]), .ext_irq_one_pin(irq_pin[1]), .vector_ack,
    .timer_zero_overflow_flag(flag[3]), .timer_one_overflow_flag(flag[2]),
    .ext_irq_zero_flag(flag[1]), .ext_irq_one_flag(flag[0]),
    .timer_one_overflow_pulse(t1_pulse));
  timer_pair_partner i_timer_pair_partner (
    .ref_clk, .rst_b, .count_en, .ack_en, .flags(flag), .count_pin, .vector_ack);

  function automatic logic [9:0] ad(input logic [7:0] i);
    return {i, 2'b00};
  endfunction

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic give_verdict();
    $display("Comparisons %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Request held until waitrequest seen low
  task automatic bus(input logic we, input logic [9:0] a, input logic [7:0] d,
                     input logic [3:0] be = 4'hF);
    int n;
    @(posedge ref_clk);
    avs_address    <= a;
    avs_writedata  <= {24'h0, d};
    avs_byteenable <= be;
    avs_write      <= we;
    avs_read       <= !we;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    check("bus answer", 32'(n < 50), 32'h1);
  endtask

  task automatic rdchk(input string name, input logic [9:0] a, input logic [31:0] exp);
    bus(1'b0, a, 8'h00);
    check(name, rd, exp);
  endtask

  task automatic wait_on(input int i, input logic lvl, input int bound);
    int n;
    n = 0;
    while (flag[i] !== lvl && n < bound) begin
      @(posedge ref_clk);
      n++;
    end
  endtask

  task automatic run_row(input bit t, input int f, input logic [7:0] mode, ctrl, lo, hi,
                         input int ticks, input logic [7:0] hia);
    int n;
    bus(1'b1, ad(IDX_CONTROL_FLAGS), 8'h00);
    bus(1'b1, ad(IDX_MODE_SELECT), mode);
    bus(1'b1, ad(t ? IDX_ONE_LOW : IDX_ZERO_LOW), lo);
    bus(1'b1, ad(t ? IDX_ONE_HIGH : IDX_ZERO_HIGH), hi);
    bus(1'b1, ad(IDX_CONTROL_FLAGS), ctrl);
    n = cyc;
    wait_on(f, 1'b1, 2000);
    n = cyc - n;
    check("ticks", 32'(n > (ticks - 1) * 12 && n <= ticks * 12 + 3), 32'h1);
    bus(1'b0, ad(IDX_CONTROL_FLAGS), 8'h00);
    check("run bits", rd & {24'h0, ctrl}, {24'h0, ctrl});
    rdchk("high byte", ad(t ? IDX_ONE_HIGH : IDX_ZERO_HIGH), {24'h0, hia});
  endtask

  initial begin
    fork
      begin
        repeat (30000) @(posedge ref_clk);
        mismatches++;
        give_verdict();
      end
    join_none
    repeat (6) @(posedge ref_clk);
    rst_b <= 1'b1;
    rdchk("control reset", ad(IDX_CONTROL_FLAGS), 32'h0);
    rdchk("mode reset", ad(IDX_MODE_SELECT), 32'h0);
    bus(1'b1, 10'h238, 8'hFF);
    rdchk("unmapped", 10'h238, 32'h0);
    rdchk("misaligned", 10'h225, 32'h0);
    bus(1'b1, ad(IDX_MODE_SELECT), 8'hA5);
    bus(1'b1, ad(IDX_MODE_SELECT), 8'h5A, 4'hE);
    rdchk("mode field", ad(IDX_MODE_SELECT), 32'hA5);
    run_row(0, 3, 8'h00, 8'h10, 8'hFE, 8'hFF, 2, 8'h00);
    run_row(0, 3, 8'h01, 8'h10, 8'hFD, 8'hFF, 3, 8'h00);
    run_row(0, 3, 8'h02, 8'h10, 8'hFC, 8'hF0, 4, 8'hF0);
    run_row(1, 2, 8'h00, 8'h40, 8'hFE, 8'hFF, 2, 8'h00);
    run_row(1, 2, 8'h10, 8'h40, 8'hFD, 8'hFF, 3, 8'h00);
    run_row(1, 2, 8'h20, 8'h40, 8'hFC, 8'hF0, 4, 8'hF0);
    check("baud pulses", pulses, 32'h3);
    run_row(0, 3, 8'h03, 8'h10, 8'hFE, 8'h55, 2, 8'h55);
    run_row(0, 2, 8'h03, 8'h40, 8'h55, 8'hFD, 3, 8'h00);
    bus(1'b1, ad(IDX_MODE_SELECT), 8'h30);
    bus(1'b1, ad(IDX_ONE_LOW), 8'h34);
    bus(1'b1, ad(IDX_CONTROL_FLAGS), 8'h40);
    repeat (60) @(posedge ref_clk);
    rdchk("held count", ad(IDX_ONE_LOW), 32'h34);
    bus(1'b1, ad(IDX_MODE_SELECT), 8'h10);
    repeat (40) @(posedge ref_clk);
    bus(1'b0, ad(IDX_ONE_LOW), 8'h00);
    check("resumed", 32'(rd[7:0] !== 8'h34), 32'h1);
    bus(1'b1, ad(IDX_CONTROL_FLAGS), 8'h00);
    bus(1'b1, ad(IDX_MODE_SELECT), 8'h05);
    bus(1'b1, ad(IDX_ZERO_LOW), 8'hFF);
    bus(1'b1, ad(IDX_ZERO_HIGH), 8'hFF);
    bus(1'b1, ad(IDX_CONTROL_FLAGS), 8'h10);
    repeat (60) @(posedge ref_clk);
    check("idle pin", flag[3], 32'h0);
    count_en <= 1'b1;
    wait_on(3, 1'b1, 200);
    check("pin edge count", flag[3], 32'h1);
    ack_en <= 1'b1;
    wait_on(3, 1'b0, 20);
    check("vector clear", flag[3], 32'h0);
    ack_en   <= 1'b0;
    count_en <= 1'b0;
    irq_pin[0] <= 1'b0;
    bus(1'b1, ad(IDX_MODE_SELECT), 8'h09);
    bus(1'b1, ad(IDX_ZERO_LOW), 8'hFF);
    bus(1'b1, ad(IDX_ZERO_HIGH), 8'hFF);
    repeat (60) @(posedge ref_clk);
    check("gate closed", flag[3], 32'h0);
    irq_pin[0] <= 1'b1;
    wait_on(3, 1'b1, 40);
    check("gate open", flag[3], 32'h1);
    for (int i = 0; i < 2; i++) begin
      bus(1'b1, ad(IDX_CONTROL_FLAGS), i ? 8'h04 : 8'h01);
      irq_pin[i] <= 1'b0;
      repeat (6) @(posedge ref_clk);
      check("edge flag", flag[1-i], 32'h1);
      ack_en <= 1'b1;
      wait_on(1 - i, 1'b0, 20);
      check("edge cleared", flag[1-i], 32'h0);
      bus(1'b1, ad(IDX_CONTROL_FLAGS), 8'h00);
      repeat (10) @(posedge ref_clk);
      check("level held", flag[1-i], 32'h1);
      irq_pin[i] <= 1'b1;
      repeat (6) @(posedge ref_clk);
      check("level released", flag[1-i], 32'h0);
      ack_en <= 1'b0;
    end
    give_verdict();
  end
endmodule
